// ### rtl/wdrs_pkg.sv
// Purpose: Shared constants and types of the watchdog and reset source block.
// Assumes: 100 MHz aclk, AXI4-Lite register access with 32-bit data.
// Notes:   Timing counts are derived from times in their own units.
package wdrs_pkg;
  // Register byte offsets.
  localparam logic [3:0] OFS_CTRL  = 4'h0;
  localparam logic [3:0] OFS_CMD   = 4'h4;
  localparam logic [3:0] OFS_COUNT = 4'h8;
  localparam logic [3:0] OFS_SYS   = 4'hC;
  // Field positions.
  localparam int CTRL_PRESC_BIT  = 0;
  localparam int CTRL_FLAGS_LSB  = 1;
  localparam int CTRL_RELOAD_LSB = 8;
  localparam int COUNT_EN_BIT    = 16;
  localparam int COUNT_INIT_BIT  = 17;
  localparam int SYS_BIDIR_BIT   = 0;
  // Reset values.
  localparam logic [7:0]  RELOAD_RST = 8'h00;
  localparam logic        PRESC_RST  = 1'b0;
  // Prescaler last counts and counter top.
  localparam logic [6:0]  DIV2_LAST   = 7'h01;
  localparam logic [6:0]  DIV128_LAST = 7'h7F;
  localparam logic [15:0] CNT_TOP     = 16'hFFFF;
  // Times in ns or TCL periods and the cycle counts derived from them.
  localparam int CLK_NS      = 10;
  localparam int TCL_NS      = 5;
  localparam int FILT_NS     = 50;
  localparam int MINPULSE_NS = 500;
  localparam int SEQ_TCL     = 1024;
  localparam int FILT_CYC    = (FILT_NS + CLK_NS - 1) / CLK_NS;
  localparam int LONG_NS     = (1032 + 12) * TCL_NS + ((4 * TCL_NS > MINPULSE_NS) ? 4 * TCL_NS : MINPULSE_NS);
  localparam int LONG_CYC    = (LONG_NS + CLK_NS - 1) / CLK_NS;
  localparam int SEQ_CYC     = (SEQ_TCL * TCL_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [2:0] FILT_LAST  = 3'(FILT_CYC - 1);
  localparam logic [9:0] FILT_START = 10'(FILT_CYC);
  localparam logic [9:0] LONG_LIM   = 10'(LONG_CYC);
  localparam logic [9:0] SEQ_LAST   = 10'(SEQ_CYC - 1);
  localparam logic [9:0] LOW_MAX    = 10'h3FF;
  // Bus responses.
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Reset cause flags, in register bit order from the top.
  typedef struct packed {
    logic poweron_flag;
    logic long_hw_flag;
    logic short_hw_flag;
    logic soft_flag;
    logic overflow_flag;
  } wdrs_flags_s;
  // Command strobes written to the command register.
  typedef struct packed {
    logic disable_req;
    logic software_reset_instr;
    logic end_of_init_instr;
    logic service;
  } wdrs_cmd_s;
  // Reset sequencer states.
  typedef enum logic [2:0] {
    ST_RUN = 3'b001,
    ST_HW  = 3'b010,
    ST_SEQ = 3'b100
  } wdrs_state_e;
endpackage

// ### rtl/wdrs_top.sv
// Purpose: Watchdog timer with reset source flags, reset pin filter and sequencer.
// Assumes: Pins are synchronous to aclk; aresetn is the power-on reset.
// Notes:   Cause flags survive every reset except aresetn.
//
// The AXI4-Lite interface to the registers and the register offsets were left to the implementer.

// Overview of operation
// - Watchdog enabled after reset; disable only pre-init.
// - Overflow forces internal reset, drives reset out.
// - Reset cause recorded as five separate flags.
// - Software reset sets only its own flag.
// - End of init clears flags; readable before.
// - 16-bit counter, prescale by 2 or 128.
// - Service loads high byte with reload value.
// - Timeout is (256 - reload) times 256 ticks.
// - Low input flagged short; long low also flagged long.
// - Input filter rejects spikes under 50 ns.
// - Mode pin low blocks driving reset input.
// - Low input with mode low resets but sets no flag.
// - Bidirectional enable cleared by every reset.
module wdrs_top
  import wdrs_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        reset_in_pin_n,
  output logic             reset_in_pin_o,
  output logic             reset_in_pin_oe,
  input  wire logic        reset_mode_pin,
  output logic             reset_out_pin_n,
  output logic             sys_reset
);

  // Decodes a mapped register offset.
  function automatic logic addr_ok(input logic [3:0] a);
    addr_ok = (a == OFS_CTRL) || (a == OFS_CMD) || (a == OFS_COUNT) || (a == OFS_SYS);
  endfunction

  // Bus state.
  logic [3:0]  aw_addr, next_aw_addr;
  logic        aw_held, next_aw_held;
  logic [31:0] w_data, next_w_data;
  logic [3:0]  w_strb, next_w_strb;
  logic        w_held, next_w_held;
  logic        next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
  logic [1:0]  next_bresp, next_rresp;
  logic [31:0] next_rdata;
  logic        wr_fire;
  // Core state.
  wdrs_state_e state, next_state;
  wdrs_flags_s flags, next_flags;
  wdrs_cmd_s   cmd;
  logic [9:0]  seq_cnt, next_seq_cnt;
  logic [9:0]  low_cnt, next_low_cnt;
  logic [2:0]  filt_cnt, next_filt_cnt;
  logic        is_async, next_is_async;
  logic        drive_req, next_drive_req;
  logic        wd_en, next_wd_en;
  logic        init_done, next_init_done;
  logic        presc, next_presc;
  logic [7:0]  reload, next_reload;
  logic        bidir_en, next_bidir_en;
  logic [6:0]  pre_cnt, next_pre_cnt;
  logic [15:0] wd_cnt, next_wd_cnt;
  logic        pin_low, filt_low, tick, wd_ovf, ev_any, enter_reset;

  // Own drive of the reset input must not read back as an external reset.
  assign pin_low  = !reset_in_pin_n && !reset_in_pin_oe;
  assign filt_low = pin_low && (filt_cnt == FILT_LAST);
  assign tick     = wd_en && (pre_cnt == (presc ? DIV128_LAST : DIV2_LAST));
  assign wd_ovf   = (state == ST_RUN) && tick && (wd_cnt == CNT_TOP) && !cmd.service && !filt_low;
  assign ev_any   = (state == ST_RUN) && (filt_low || wd_ovf || cmd.software_reset_instr);
  assign wr_fire  = aw_held && w_held && !s_axi_bvalid;
  assign cmd      = (wr_fire && aw_addr == OFS_CMD && w_strb[0]) ? wdrs_cmd_s'(w_data[3:0]) : '0;

  // AXI4-Lite slave: address and data taken in either order, answer after both.
  always_comb begin
    next_aw_addr = aw_addr;
    next_aw_held = aw_held;
    next_w_data  = w_data;
    next_w_strb  = w_strb;
    next_w_held  = w_held;
    next_bvalid  = s_axi_bvalid;
    next_bresp   = s_axi_bresp;
    next_rvalid  = s_axi_rvalid;
    next_rresp   = s_axi_rresp;
    next_rdata   = s_axi_rdata;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_addr = s_axi_awaddr;
      next_aw_held = 1'b1;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
      next_w_held = 1'b1;
    end
    if (wr_fire) begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = addr_ok(aw_addr) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rresp  = addr_ok(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      next_rdata  = 32'h0;
      case (s_axi_araddr)
        OFS_CTRL: begin
          next_rdata[CTRL_PRESC_BIT] = presc;
          next_rdata[CTRL_FLAGS_LSB +: 5] = flags;
          next_rdata[CTRL_RELOAD_LSB +: 8] = reload;
        end
        OFS_COUNT: begin
          next_rdata[15:0] = wd_cnt;
          next_rdata[COUNT_EN_BIT] = wd_en;
          next_rdata[COUNT_INIT_BIT] = init_done;
        end
        OFS_SYS: next_rdata[SYS_BIDIR_BIT] = bidir_en;
        default: next_rdata = 32'h0;
      endcase
    end
    next_awready = !next_aw_held && !next_bvalid;
    next_wready  = !next_w_held && !next_bvalid;
    next_arready = !next_rvalid;
  end

  // Registers the bus state.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_addr       <= 4'h0;
      aw_held       <= 1'b0;
      w_data        <= 32'h0;
      w_strb        <= 4'h0;
      w_held        <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rresp   <= RESP_OKAY;
      s_axi_rdata   <= 32'h0;
    end else begin
      aw_addr       <= next_aw_addr;
      aw_held       <= next_aw_held;
      w_data        <= next_w_data;
      w_strb        <= next_w_strb;
      w_held        <= next_w_held;
      s_axi_awready <= next_awready;
      s_axi_wready  <= next_wready;
      s_axi_bvalid  <= next_bvalid;
      s_axi_bresp   <= next_bresp;
      s_axi_arready <= next_arready;
      s_axi_rvalid  <= next_rvalid;
      s_axi_rresp   <= next_rresp;
      s_axi_rdata   <= next_rdata;
    end
  end

  // Watchdog, pin filter and reset sequencer.
  always_comb begin
    next_state     = state;
    next_flags     = flags;
    next_seq_cnt   = seq_cnt;
    next_low_cnt   = low_cnt;
    next_is_async  = is_async;
    next_drive_req = drive_req;
    next_wd_en     = wd_en;
    next_init_done = init_done;
    next_presc     = presc;
    next_reload    = reload;
    next_bidir_en  = bidir_en;
    next_pre_cnt   = pre_cnt;
    next_wd_cnt    = wd_cnt;
    enter_reset    = 1'b0;
    next_filt_cnt  = (pin_low && filt_cnt != FILT_LAST) ? filt_cnt + 3'h1 : (pin_low ? filt_cnt : 3'h0);
    case (state)
      ST_RUN: begin
        if (wr_fire && aw_addr == OFS_CTRL) begin
          if (w_strb[0]) next_presc = w_data[CTRL_PRESC_BIT];
          if (w_strb[1]) next_reload = w_data[CTRL_RELOAD_LSB +: 8];
        end
        if (wr_fire && aw_addr == OFS_SYS && w_strb[0]) next_bidir_en = w_data[SYS_BIDIR_BIT];
        if (cmd.disable_req && !init_done) next_wd_en = 1'b0;
        if (cmd.end_of_init_instr) begin
          next_init_done = 1'b1;
          next_flags     = '0;
        end
        if (cmd.service) begin
          next_wd_cnt  = {reload, 8'h00};
          next_pre_cnt = 7'h00;
        end else if (wd_en) begin
          next_pre_cnt = tick ? 7'h00 : pre_cnt + 7'h01;
          if (tick) next_wd_cnt = wd_cnt + 16'h0001;
        end
        // Set wins over the clear done above.
        if (filt_low) begin
          next_state    = ST_HW;
          next_is_async = !reset_mode_pin;
          next_low_cnt  = FILT_START;
          enter_reset   = 1'b1;
        end else if (wd_ovf) begin
          next_flags.overflow_flag = 1'b1;
          next_state     = ST_SEQ;
          next_drive_req = bidir_en;
          enter_reset    = 1'b1;
        end else if (cmd.software_reset_instr) begin
          next_flags.soft_flag = 1'b1;
          next_state     = ST_SEQ;
          next_drive_req = bidir_en;
          enter_reset    = 1'b1;
        end
      end
      ST_HW: begin
        if (pin_low) begin
          if (low_cnt != LOW_MAX) next_low_cnt = low_cnt + 10'h001;
        end else begin
          if (!is_async) begin
            next_flags.short_hw_flag = 1'b1;
            if (low_cnt > LONG_LIM) next_flags.long_hw_flag = 1'b1;
          end
          next_state = ST_SEQ;
        end
      end
      ST_SEQ: begin
        next_seq_cnt = seq_cnt + 10'h001;
        if (seq_cnt == SEQ_LAST) begin
          next_state     = ST_RUN;
          next_drive_req = 1'b0;
        end
      end
      default: next_state = ST_RUN;
    endcase
    if (enter_reset) begin
      next_wd_en     = 1'b1;
      next_init_done = 1'b0;
      next_presc     = PRESC_RST;
      next_reload    = RELOAD_RST;
      next_bidir_en  = 1'b0;
      next_pre_cnt   = 7'h00;
      next_wd_cnt    = 16'h0000;
      next_seq_cnt   = 10'h000;
    end
  end

  // Registers core state; outputs follow the next state.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state           <= ST_RUN;
      flags           <= 5'h10;
      seq_cnt         <= 10'h000;
      low_cnt         <= 10'h000;
      filt_cnt        <= 3'h0;
      is_async        <= 1'b0;
      drive_req       <= 1'b0;
      wd_en           <= 1'b1;
      init_done       <= 1'b0;
      presc           <= PRESC_RST;
      reload          <= RELOAD_RST;
      bidir_en        <= 1'b0;
      pre_cnt         <= 7'h00;
      wd_cnt          <= 16'h0000;
      reset_out_pin_n <= 1'b0;
      sys_reset       <= 1'b1;
      reset_in_pin_o  <= 1'b0;
      reset_in_pin_oe <= 1'b0;
    end else begin
      state           <= next_state;
      flags           <= next_flags;
      seq_cnt         <= next_seq_cnt;
      low_cnt         <= next_low_cnt;
      filt_cnt        <= next_filt_cnt;
      is_async        <= next_is_async;
      drive_req       <= next_drive_req;
      wd_en           <= next_wd_en;
      init_done       <= next_init_done;
      presc           <= next_presc;
      reload          <= next_reload;
      bidir_en        <= next_bidir_en;
      pre_cnt         <= next_pre_cnt;
      wd_cnt          <= next_wd_cnt;
      reset_out_pin_n <= (next_state == ST_RUN);
      sys_reset       <= (next_state != ST_RUN);
      reset_in_pin_o  <= 1'b0;
      reset_in_pin_oe <= next_drive_req && (next_state == ST_SEQ) && reset_mode_pin;
    end
  end

  // Checks on the sequencer and the watchdog.
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  property p_ovf_reset;
    wd_ovf |=> !reset_out_pin_n && sys_reset && flags.overflow_flag;
  endproperty
  a_ovf_reset: assert property (p_ovf_reset) else $error("overflow did not reset");

  property p_enabled_on_exit;
    (state == ST_SEQ && seq_cnt == SEQ_LAST) |=> wd_en && !init_done && reset_out_pin_n;
  endproperty
  a_enabled_on_exit: assert property (p_enabled_on_exit) else $error("watchdog off after reset");

  property p_disable_ignored;
    (state == ST_RUN && init_done && wd_en && !ev_any) |=> wd_en;
  endproperty
  a_disable_ignored: assert property (p_disable_ignored) else $error("watchdog disabled after init");

  property p_soft_only;
    (state == ST_RUN && cmd.software_reset_instr && !filt_low && !wd_ovf) |=>
      flags.soft_flag && (state == ST_SEQ) &&
      (flags.overflow_flag == ($past(flags.overflow_flag) && !$past(cmd.end_of_init_instr))) &&
      (flags.short_hw_flag == ($past(flags.short_hw_flag) && !$past(cmd.end_of_init_instr)));
  endproperty
  a_soft_only: assert property (p_soft_only) else $error("software reset flags wrong");

  property p_end_of_init_instr_clear;
    (state == ST_RUN && cmd.end_of_init_instr && !ev_any) |=> (flags == '0) && init_done;
  endproperty
  a_end_of_init_instr_clear: assert property (p_end_of_init_instr_clear) else $error("flags not cleared at init");

  property p_service_load;
    (state == ST_RUN && cmd.service && !ev_any) |=> wd_cnt == {$past(reload), 8'h00};
  endproperty
  a_service_load: assert property (p_service_load) else $error("service load wrong");

  property p_count_step;
    (state == ST_RUN && wd_en && !cmd.service && !ev_any) |=> wd_cnt == ($past(wd_cnt) + {15'h0000, $past(tick)});
  endproperty
  a_count_step: assert property (p_count_step) else $error("counter step wrong");

  property p_div2_spacing;
    (tick && !presc) |=> !tick;
  endproperty
  a_div2_spacing: assert property (p_div2_spacing) else $error("prescale two ticks too fast");

  property p_bidir_inhibit;
    !reset_mode_pin |=> !reset_in_pin_oe;
  endproperty
  a_bidir_inhibit: assert property (p_bidir_inhibit) else $error("reset input driven with mode low");

  property p_bidir_clear;
    (state != ST_RUN) |-> !bidir_en;
  endproperty
  a_bidir_clear: assert property (p_bidir_clear) else $error("bidirectional enable kept in reset");

  property p_spike_reject;
    (state == ST_RUN && !pin_low) ##1 (state == ST_RUN && pin_low) [*4] ##1 !pin_low |=> state != ST_HW;
  endproperty
  a_spike_reject: assert property (p_spike_reject) else $error("short spike accepted");

  property p_long_flag;
    (state == ST_HW && !pin_low && !is_async) |=> flags.short_hw_flag &&
      (flags.long_hw_flag == ($past(low_cnt) > LONG_LIM || $past(flags.long_hw_flag)));
  endproperty
  a_long_flag: assert property (p_long_flag) else $error("hardware reset flag wrong");

  c_overflow: cover property (wd_ovf);
  c_soft: cover property (state == ST_RUN && cmd.software_reset_instr);
  c_long: cover property (state == ST_HW && !pin_low && low_cnt > LONG_LIM);
  c_async: cover property (state == ST_RUN && filt_low && !reset_mode_pin);

endmodule

// ### testbench/wdrs_rst_ext.sv
// Purpose: Model of the board circuit that pulls the reset input pin low.
// Assumes: The pin has a pull-up, so it reads high when nobody pulls it.
// Notes:   The bench picks the pulse length, including spikes that are too short.
module wdrs_rst_ext
  import wdrs_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        go,
  input  wire logic [11:0] len,
  input  wire logic        pin_o,
  input  wire logic        pin_oe,
  output logic             pin_n,
  output logic             busy
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [11:0] cnt = 12'h000;

  // Low pulse length.
  // Loads the commanded low time and counts it down.
  always @(posedge aclk) begin
    if (go) begin
      cnt <= len;
    end else if (cnt != 12'h000) begin
      cnt <= cnt - 12'h001;
    end
  end

  // The wired level is low when this circuit or the device pulls it down.
  assign pin_n = !((cnt != 12'h000) || (pin_oe && !pin_o));
  assign busy  = (cnt != 12'h000);
endmodule

// ### testbench/wdrs_tb_top.sv
// Purpose: Self-checking bench for the watchdog and reset source block.
// Assumes: 100 MHz aclk; bus tasks start on a rising edge and sample at the falling one.
// Notes:   Expected values follow the package register map and timing counts.
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin err_count++; \
  $display("MISMATCH t=%0t got %0h exp %0h", $time, (a), (e)); end end
module wdrs_tb_top
  import wdrs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int CYC_MAX = 20000;
  logic        aclk = 1'b0;
  logic        aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rr, br;
  logic        pin_n, pin_o, pin_oe, reset_mode_pin, reset_out_pin_n, sys_reset, go;
  logic [11:0] len;
  int          err_count, comparisons, cyc;

  wdrs_top u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .reset_in_pin_n(pin_n),
    .reset_in_pin_o(pin_o), .reset_in_pin_oe(pin_oe), .reset_mode_pin, .reset_out_pin_n, .sys_reset);
  wdrs_rst_ext u_ext (.aclk, .go, .len, .pin_o, .pin_oe, .pin_n, .busy());

  // Clock generation.
  always #5 aclk = ~aclk;

  // Cuts a hung run short.
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == CYC_MAX) begin
      err_count++;
      $display("MISMATCH t=%0t timeout", $time);
      finish_test();
    end
  end

  task automatic finish_test();
    if (err_count == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // Write one word; each channel is released after its own handshake.
  task automatic axw(input logic [3:0] a, input logic [31:0] d);
    logic ha, hw, hb;
    hb = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!hb) begin
      @(negedge aclk);
      ha = s_axi_awvalid && s_axi_awready;
      hw = s_axi_wvalid && s_axi_wready;
      hb = s_axi_bvalid;
      br = s_axi_bresp;
      @(posedge aclk);
      if (ha) s_axi_awvalid <= 1'b0;
      if (hw) s_axi_wvalid <= 1'b0;
      if (hb) s_axi_bready <= 1'b0;
    end
  endtask

  // Read one word into rd and rr.
  task automatic axr(input logic [3:0] a);
    logic h, hr;
    hr = 1'b0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!hr) begin
      @(negedge aclk);
      h = s_axi_arvalid && s_axi_arready;
      hr = s_axi_rvalid;
      rd = s_axi_rdata;
      rr = s_axi_rresp;
      @(posedge aclk);
      if (h) s_axi_arvalid <= 1'b0;
      if (hr) s_axi_rready <= 1'b0;
    end
  endtask

  // Waits at falling edges until the reset output reaches v, at most m cycles.
  task automatic wait_out(input logic v, input int m);
    int n;
    n = 0;
    @(negedge aclk);
    while (reset_out_pin_n !== v && n < m) begin
      @(negedge aclk);
      n++;
    end
  endtask

  task automatic por();
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
  endtask

  task automatic pin_pulse(input logic [11:0] n, input logic m);
    @(posedge aclk);
    reset_mode_pin <= m;
    go <= 1'b1;
    len <= n;
    @(posedge aclk);
    go <= 1'b0;
  endtask

  // Power-on values, unmapped accesses and a single-lane control write.
  task automatic t_por();
    por();
    axr(OFS_CTRL);
    `CHK(rd, 32'h00000020)
    axr(OFS_SYS);
    `CHK(rd[0], 1'b0)
    axr(OFS_COUNT);
    `CHK(rd[16], 1'b1)
    axr(4'h6);
    `CHK(rr, RESP_SLVERR)
    `CHK(rd, 32'h00000000)
    axw(4'h6, 32'h0000FF01);
    `CHK(br, RESP_SLVERR)
    s_axi_wstrb <= 4'h1;
    axw(OFS_CTRL, 32'h0000FF01);
    s_axi_wstrb <= 4'hF;
    `CHK(br, RESP_OKAY)
    axr(OFS_CTRL);
    `CHK(rd, 32'h00000021)
  endtask

  // Disable is honoured before end of init only; end of init clears flags.
  task automatic t_disable();
    axw(OFS_CMD, 32'h00000008);
    axr(OFS_COUNT);
    `CHK(rd[16], 1'b0)
    por();
    axw(OFS_CMD, 32'h00000002);
    axr(OFS_CTRL);
    `CHK(rd, 32'h00000000)
    axw(OFS_CMD, 32'h00000008);
    axr(OFS_COUNT);
    `CHK(rd[17:16], 2'b11)
  endtask

  // Divide by 128: two ticks in about 310 cycles after a service.
  task automatic t_prescale();
    axw(OFS_CTRL, 32'h0000FF01);
    axw(OFS_CMD, 32'h00000001);
    axr(OFS_COUNT);
    `CHK(rd[15:8], 8'hFF)
    `CHK(rd[7:0], 8'h00)
    repeat (300) @(negedge aclk);
    axr(OFS_COUNT);
    `CHK(rd[15:0], 16'hFF02)
  endtask

  // Reload FF at divide by 2 overflows 512 cycles after the service.
  task automatic t_timeout();
    axw(OFS_CTRL, 32'h0000FF00);
    axw(OFS_CMD, 32'h00000001);
    repeat (495) @(negedge aclk);
    `CHK(reset_out_pin_n, 1'b1)
    wait_out(1'b0, 30);
    `CHK(reset_out_pin_n, 1'b0)
    `CHK(sys_reset, 1'b1)
    wait_out(1'b1, 600);
    axr(OFS_CTRL);
    `CHK(rd, 32'h00000002)
    axr(OFS_COUNT);
    `CHK(rd[17:16], 2'b01)
  endtask

  // Software reset with bidirectional reset, mode pin high then low.
  task automatic t_soft();
    axw(OFS_CMD, 32'h00000002);
    axw(OFS_SYS, 32'h00000001);
    axw(OFS_CMD, 32'h00000004);
    wait_out(1'b0, 5);
    repeat (3) @(negedge aclk);
    `CHK(pin_oe, 1'b1)
    `CHK(pin_n, 1'b0)
    wait_out(1'b1, 600);
    axr(OFS_CTRL);
    `CHK(rd, 32'h00000004)
    axr(OFS_SYS);
    `CHK(rd[0], 1'b0)
    axw(OFS_CMD, 32'h00000002);
    axw(OFS_SYS, 32'h00000001);
    reset_mode_pin <= 1'b0;
    axw(OFS_CMD, 32'h00000004);
    wait_out(1'b0, 5);
    repeat (3) @(negedge aclk);
    `CHK(pin_oe, 1'b0)
    wait_out(1'b1, 600);
  endtask

  // Four-sample spike, short and long pulses at the threshold, and a five-sample asynchronous pulse.
  task automatic t_pin();
    logic [11:0] lens [4];
    logic        modes [4];
    logic [31:0] expv [4];
    lens = '{12'h004, 12'h23C, 12'h23D, 12'h005};
    modes = '{1'b1, 1'b1, 1'b1, 1'b0};
    expv = '{32'h00000000, 32'h00000008, 32'h00000018, 32'h00000000};
    for (int i = 0; i < 4; i++) begin
      axw(OFS_CMD, 32'h00000002);
      pin_pulse(lens[i], modes[i]);
      if (i == 0) begin
        repeat (15) @(negedge aclk);
        `CHK(reset_out_pin_n, 1'b1)
      end else begin
        wait_out(1'b0, 10);
        `CHK(reset_out_pin_n, 1'b0)
        wait_out(1'b1, 1400);
      end
      axr(OFS_CTRL);
      `CHK(rd, expv[i])
    end
  endtask

  // Main sequence.
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, go} = 7'h00;
    {s_axi_awaddr, s_axi_araddr} = 8'h00;
    s_axi_wstrb = 4'hF;
    s_axi_wdata = 32'h00000000;
    reset_mode_pin = 1'b1;
    len = 12'h000;
    err_count = 0;
    comparisons = 0;
    cyc = 0;
    t_por();
    t_disable();
    t_prescale();
    t_timeout();
    t_soft();
    t_pin();
    finish_test();
  end
endmodule
